//--- include/scb_pkg.sv
// Contract
// - Block write and block read framing honored.
// - Stop after any byte keeps completed bytes.
// - Answer only address 1101 plus strap bits.
// - Byte 0 per-output enables, reset one.
// - Byte 1 bits 7:6 read strap mode.
// - Byte 1 bit 5 selects mode source.
// - Software mode bits act only when selected.
// - Byte 2 per-output edge rate, reset one.
// - Byte 3 bit 5 enables software frequency.
// - Frequency field acts only when enabled.
// - Byte 3 bit 0 feedback edge rate.
// - Byte 5 read-only revision and vendor.
package scb_pkg;
  localparam logic [3:0] SCB_ADDR_HI = 4'hD;
  localparam logic [7:0] SCB_IDX_OE = 8'h00;
  localparam logic [7:0] SCB_IDX_PLL = 8'h01;
  localparam logic [7:0] SCB_IDX_SLEW = 8'h02;
  localparam logic [7:0] SCB_IDX_FREQ = 8'h03;
  localparam logic [7:0] SCB_IDX_RSVD4 = 8'h04;
  localparam logic [7:0] SCB_IDX_ID = 8'h05;
  localparam logic [7:0] SCB_NUM_BYTES = 8'h06;
  // Writable bits per byte; everything else is fixed
  localparam logic [7:0] SCB_MASK_OE = 8'h5A;
  localparam logic [7:0] SCB_MASK_PLL = 8'h3B;
  localparam logic [7:0] SCB_MASK_SLEW = 8'h5A;
  localparam logic [7:0] SCB_MASK_FREQ = 8'h39;
  localparam logic [7:0] SCB_RST_OE = 8'h5A;
  localparam logic [7:0] SCB_RST_PLL = 8'h06;
  localparam logic [7:0] SCB_RST_SLEW = 8'hFF;
  localparam logic [7:0] SCB_RST_FREQ = 8'hC7;
  localparam logic [7:0] SCB_RST_RSVD4 = 8'hFF;
  localparam int SCB_POS_PLL_SW_SEL = 5;
  localparam int SCB_POS_FREQ_EN = 5;
  // Per-output bit positions, shared by the enable and edge-rate bytes
  localparam int SCB_POS_Q3 = 6;
  localparam int SCB_POS_Q2 = 4;
  localparam int SCB_POS_Q1 = 3;
  localparam int SCB_POS_Q0 = 1;
  localparam int SCB_POS_PLL_SW_LO = 3;
  localparam int SCB_POS_SWING_LO = 0;
  localparam int SCB_POS_FREQ_SEL_LO = 3;
  localparam int SCB_POS_FB_EDGE = 0;
  localparam logic [3:0] SCB_BYTE_BITS = 4'h8;
  // Identity codes: arbitrary neutral values
  localparam logic [3:0] SCB_REVISION_CODE = 4'h1;
  localparam logic [3:0] SCB_VENDOR_CODE = 4'h5;
  typedef enum logic [2:0] {
    SCB_IDLE = 3'b000,
    SCB_ADDR = 3'b001,
    SCB_RX = 3'b010,
    SCB_TX = 3'b011,
    SCB_ACK = 3'b100,
    SCB_RACK = 3'b101,
    SCB_SKIP = 3'b110
  } scb_state_t;
endpackage

//--- core/scb_smbus_config.sv
`timescale 1ns/100ps
module scb_smbus_config (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // SMBus pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Power-up straps
  input wire logic [2:0] slave_addr_strap,
  input wire logic [1:0] loop_bandwidth_strap,
  // Controls to the clock core
  output logic [3:0] out_enable,
  output logic [1:0] pll_mode,
  output logic [1:0] swing_sel,
  output logic [3:0] out_edge_fast,
  output logic rate_sw_enable,
  output logic [1:0] rate_select,
  output logic feedback_edge_fast
);
  import scb_pkg::*;

  logic [1:0] scl_s, sda_s;
  logic scl_q, sda_q;
  logic strap_done;
  logic [2:0] addr_lo;
  logic [1:0] pll_strap;
  logic [2:0] addr_strap_s0, addr_strap_s1;
  logic [1:0] bw_strap_s0, bw_strap_s1;
  logic [7:0] output_enable_ctrl, pll_mode_amplitude_ctrl, output_slew_ctrl;
  logic [7:0] frequency_select_ctrl;
  scb_state_t state;
  logic [7:0] shift;
  logic [3:0] bitcnt;
  logic [1:0] phase;
  logic is_read;
  logic [7:0] index, count;
  logic wr_en;
  logic [7:0] wr_idx, wr_data;
  logic [7:0] rd_byte;
  logic scl_rise, scl_fall, start_c, stop_c;

  // Two-stage synchronisers, edges seen on second stage only
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_s <= 2'b11;
      sda_s <= 2'b11;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], scl};
      sda_s <= {sda_s[0], sda_in};
      scl_q <= scl_s[1];
      sda_q <= sda_s[1];
    end
  end
  assign scl_rise = scl_s[1] && !scl_q;
  assign scl_fall = !scl_s[1] && scl_q;
  assign start_c = scl_s[1] && scl_q && sda_q && !sda_s[1];
  assign stop_c = scl_s[1] && scl_q && !sda_q && sda_s[1];

  // Straps are pins too; two stages before the capture below
  always_ff @(posedge clk) begin
    addr_strap_s0 <= slave_addr_strap;
    addr_strap_s1 <= addr_strap_s0;
    bw_strap_s0 <= loop_bandwidth_strap;
    bw_strap_s1 <= bw_strap_s0;
  end

  // Straps caught once after reset release
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_done <= 1'b0;
      addr_lo <= 3'h0;
      pll_strap <= 2'h0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      addr_lo <= addr_strap_s1;
      pll_strap <= bw_strap_s1;
    end
  end

  // Read data multiplexer
  always_comb begin
    if (index == SCB_IDX_OE) begin
      rd_byte = output_enable_ctrl;
    end else if (index == SCB_IDX_PLL) begin
      rd_byte = {pll_strap, pll_mode_amplitude_ctrl[5:0]};
    end else if (index == SCB_IDX_SLEW) begin
      rd_byte = output_slew_ctrl;
    end else if (index == SCB_IDX_FREQ) begin
      rd_byte = frequency_select_ctrl;
    end else if (index == SCB_IDX_RSVD4) begin
      rd_byte = SCB_RST_RSVD4;
    end else if (index == SCB_IDX_ID) begin
      rd_byte = {SCB_REVISION_CODE, SCB_VENDOR_CODE};
    end else begin
      rd_byte = 8'h00;
    end
  end

  // Protocol engine; phase: 0 index, 1 count, 2 data
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= SCB_IDLE;
      shift <= 8'h00;
      bitcnt <= 4'h0;
      phase <= 2'h0;
      is_read <= 1'b0;
      index <= 8'h00;
      count <= 8'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      wr_en <= 1'b0;
      wr_idx <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (stop_c) begin
        state <= SCB_IDLE;
        sda_oe <= 1'b0;
      end else if (start_c) begin
        state <= SCB_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          SCB_ADDR, SCB_RX: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_s[1]};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == SCB_BYTE_BITS) begin
              bitcnt <= 4'h0;
              if (state == SCB_ADDR) begin
                if (shift[7:1] == {SCB_ADDR_HI, addr_lo}) begin
                  is_read <= shift[0];
                  sda_oe <= 1'b1;
                  state <= SCB_ACK;
                  if (!shift[0]) begin
                    phase <= 2'h0;
                  end
                end else begin
                  state <= SCB_SKIP;
                end
              end else begin
                sda_oe <= 1'b1;
                state <= SCB_ACK;
                if (phase == 2'h0) begin
                  index <= shift;
                  phase <= 2'h1;
                end else if (phase == 2'h1) begin
                  count <= shift;
                  phase <= 2'h2;
                end else if (count != 8'h00) begin
                  wr_en <= 1'b1;
                  wr_idx <= index;
                  wr_data <= shift;
                  index <= index + 8'h01;
                  count <= count - 8'h01;
                end
              end
            end
          end
          SCB_ACK: begin
            if (scl_fall) begin
              if (is_read) begin
                // Count byte goes first, then data from index
                shift <= (phase == 2'h1) ? SCB_NUM_BYTES - index : rd_byte;
                sda_out <= 1'b0;
                sda_oe <= ((phase == 2'h1) ? SCB_NUM_BYTES - index : rd_byte) >= 8'h80
                          ? 1'b0 : 1'b1;
                bitcnt <= 4'h1;
                state <= SCB_TX;
              end else begin
                sda_oe <= 1'b0;
                state <= SCB_RX;
              end
            end
          end
          SCB_TX: begin
            if (scl_fall) begin
              if (bitcnt == SCB_BYTE_BITS) begin
                sda_oe <= 1'b0;
                state <= SCB_RACK;
                if (phase == 2'h1) begin
                  phase <= 2'h2;
                end else begin
                  index <= index + 8'h01;
                end
              end else begin
                sda_oe <= !shift[3'h7 - bitcnt[2:0]];
                bitcnt <= bitcnt + 4'h1;
              end
            end
          end
          SCB_RACK: begin
            if (scl_rise) begin
              if (sda_s[1]) begin
                state <= SCB_SKIP;
              end else begin
                state <= SCB_ACK;
              end
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Register writes; reserved bits never take write data
  always_ff @(posedge clk) begin
    if (rst) begin
      output_enable_ctrl <= SCB_RST_OE;
    end else if (wr_en && wr_idx == SCB_IDX_OE) begin
      output_enable_ctrl <= (wr_data & SCB_MASK_OE) | (SCB_RST_OE & ~SCB_MASK_OE);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pll_mode_amplitude_ctrl <= SCB_RST_PLL;
    end else if (wr_en && wr_idx == SCB_IDX_PLL) begin
      pll_mode_amplitude_ctrl <= (wr_data & SCB_MASK_PLL) | (SCB_RST_PLL & ~SCB_MASK_PLL);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      output_slew_ctrl <= SCB_RST_SLEW;
    end else if (wr_en && wr_idx == SCB_IDX_SLEW) begin
      output_slew_ctrl <= (wr_data & SCB_MASK_SLEW) | (SCB_RST_SLEW & ~SCB_MASK_SLEW);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      frequency_select_ctrl <= SCB_RST_FREQ;
    end else if (wr_en && wr_idx == SCB_IDX_FREQ) begin
      frequency_select_ctrl <= (wr_data & SCB_MASK_FREQ) | (SCB_RST_FREQ & ~SCB_MASK_FREQ);
    end
  end

  // Output enables; a 0 overrides the pin and forces the stop state
  always_ff @(posedge clk) begin
    if (rst) begin
      out_enable <= {SCB_RST_OE[SCB_POS_Q3], SCB_RST_OE[SCB_POS_Q2],
                     SCB_RST_OE[SCB_POS_Q1], SCB_RST_OE[SCB_POS_Q0]};
    end else begin
      out_enable <= {output_enable_ctrl[SCB_POS_Q3], output_enable_ctrl[SCB_POS_Q2],
                     output_enable_ctrl[SCB_POS_Q1], output_enable_ctrl[SCB_POS_Q0]};
    end
  end

  // Effective PLL mode; the software field is ignored until selected
  always_ff @(posedge clk) begin
    if (rst) begin
      pll_mode <= 2'h0;
    end else if (pll_mode_amplitude_ctrl[SCB_POS_PLL_SW_SEL]) begin
      pll_mode <= pll_mode_amplitude_ctrl[SCB_POS_PLL_SW_LO +: 2];
    end else begin
      pll_mode <= pll_strap;
    end
  end

  // Output amplitude code
  always_ff @(posedge clk) begin
    if (rst) begin
      swing_sel <= SCB_RST_PLL[SCB_POS_SWING_LO +: 2];
    end else begin
      swing_sel <= pll_mode_amplitude_ctrl[SCB_POS_SWING_LO +: 2];
    end
  end

  // Per-output edge rate, 1 is fast
  always_ff @(posedge clk) begin
    if (rst) begin
      out_edge_fast <= {SCB_RST_SLEW[SCB_POS_Q3], SCB_RST_SLEW[SCB_POS_Q2],
                        SCB_RST_SLEW[SCB_POS_Q1], SCB_RST_SLEW[SCB_POS_Q0]};
    end else begin
      out_edge_fast <= {output_slew_ctrl[SCB_POS_Q3], output_slew_ctrl[SCB_POS_Q2],
                        output_slew_ctrl[SCB_POS_Q1], output_slew_ctrl[SCB_POS_Q0]};
    end
  end

  // Software frequency selection; the field shows 00 while disabled
  always_ff @(posedge clk) begin
    if (rst) begin
      rate_sw_enable <= SCB_RST_FREQ[SCB_POS_FREQ_EN];
      rate_select <= 2'h0;
    end else begin
      rate_sw_enable <= frequency_select_ctrl[SCB_POS_FREQ_EN];
      if (frequency_select_ctrl[SCB_POS_FREQ_EN]) begin
        rate_select <= frequency_select_ctrl[SCB_POS_FREQ_SEL_LO +: 2];
      end else begin
        rate_select <= 2'h0;
      end
    end
  end

  // Feedback edge rate, 1 is fast
  always_ff @(posedge clk) begin
    if (rst) begin
      feedback_edge_fast <= SCB_RST_FREQ[SCB_POS_FB_EDGE];
    end else begin
      feedback_edge_fast <= frequency_select_ctrl[SCB_POS_FB_EDGE];
    end
  end
endmodule

//--- dv/scb_smbus_config_props.sv
`timescale 1ns/100ps
module scb_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus pins
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Controls
  input wire logic [3:0] out_enable,
  input wire logic [1:0] pll_mode,
  input wire logic [1:0] swing_sel,
  input wire logic [3:0] out_edge_fast,
  input wire logic rate_sw_enable,
  input wire logic [1:0] rate_select,
  input wire logic feedback_edge_fast
);
  default clocking @(posedge clk); endclocking
  rst_ctrl_a: assert property (rst |=> out_enable == 4'hF && out_edge_fast == 4'hF)
    else $error("output controls not at reset value");
  rst_fields_a: assert property (rst |=> swing_sel == 2'h2 && feedback_edge_fast)
    else $error("swing or feedback edge not at reset value");
  rst_bus_a: assert property (rst |=> !sda_oe && !rate_sw_enable)
    else $error("bus or rate enable active after reset");
  drain_a: assert property (disable iff (rst) sda_out == 1'b0)
    else $error("data pin driven high");
  ack_edge_a: assert property (disable iff (rst) $rose(sda_oe) |-> !scl)
    else $error("data pulled low while clock high");
  sda_hold_a: assert property (disable iff (rst) scl && $past(scl) |-> $stable(sda_oe))
    else $error("data changed while clock high");
  ctrl_time_a: assert property (disable iff (rst)
    !$stable(out_enable) || !$stable(out_edge_fast) |-> !scl)
    else $error("output control changed outside byte end");
  rate_gate_a: assert property (disable iff (rst) !rate_sw_enable |-> rate_select == 2'h0)
    else $error("rate select active while disabled");
endmodule

//--- dv/scb_host.sv
`timescale 1ns/100ps
module scb_host (
  // Clock
  input wire logic clk,
  // Bus
  input wire logic sda_oe,
  output logic scl,
  output logic sda_in,
  // Read result
  output logic [7:0] rd_byte,
  output logic rd_stb
);
  logic hold_low;
  // Pull-up: line is high unless someone pulls it low
  assign sda_in = !(hold_low || sda_oe);
  initial begin
    scl = 1'b1;
    hold_low = 1'b0;
    rd_byte = 8'h00;
    rd_stb = 1'b0;
  end
  task automatic hp;
    repeat (6) @(posedge clk);
  endtask
  task automatic pulse(input logic b, output logic s);
    @(posedge clk);
    hold_low <= !b;
    hp;
    scl <= 1'b1;
    hp;
    s = sda_in;
    scl <= 1'b0;
  endtask
  task automatic start;
    @(posedge clk);
    hold_low <= 1'b0;
    hp;
    scl <= 1'b1;
    hp;
    hold_low <= 1'b1;
    hp;
    scl <= 1'b0;
  endtask
  task automatic stop;
    @(posedge clk);
    hold_low <= 1'b1;
    hp;
    scl <= 1'b1;
    hp;
    hold_low <= 1'b0;
    hp;
  endtask
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) pulse(d[i], q[i]);
    pulse(!mack, ack);
    ack = !ack;
  endtask
  task automatic get(input logic mack);
    logic [7:0] q;
    logic a;
    xfer(8'hFF, mack, q, a);
    rd_byte <= q;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
  endtask
endmodule

//--- dv/tb_scb_smbus_config.sv
`timescale 1ns/100ps
module tb_scb_smbus_config;
  import scb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] adr_strap;
  logic [1:0] bw_strap;
  logic scl, sda_in, sda_out, sda_oe, rd_stb, rate_sw_enable, feedback_edge_fast, a;
  logic [3:0] out_enable, out_edge_fast;
  logic [1:0] pll_mode, swing_sel, rate_select;
  logic [7:0] rd_byte, q;
  logic [7:0] e [0:5];
  logic [7:0] m [0:3] = '{SCB_MASK_OE, SCB_MASK_PLL, SCB_MASK_SLEW, SCB_MASK_FREQ};
  logic [7:0] exp_q [$];
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  integer seed = 32'h0db9;
  always #20 clk = !clk;
  scb_smbus_config u_scb_smbus_config (.clk, .rst, .scl, .sda_in, .sda_out, .sda_oe,
    .slave_addr_strap(adr_strap), .loop_bandwidth_strap(bw_strap), .out_enable, .pll_mode,
    .swing_sel, .out_edge_fast, .rate_sw_enable, .rate_select, .feedback_edge_fast);
  scb_host u_scb_host (.clk, .sda_oe, .scl, .sda_in, .rd_byte, .rd_stb);
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    n_checks++;
    if (got !== want) begin
      mismatches++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, want);
    end
  endtask
  task automatic complete_run;
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic send(input logic [7:0] d);
    u_scb_host.xfer(d, 1'b0, q, a);
    check({7'h0, a}, 8'h01);
  endtask
  task automatic wr_blk(input int idx, input int n, input int sent);
    logic [7:0] d;
    u_scb_host.start;
    send({SCB_ADDR_HI, adr_strap, 1'b0});
    send(idx[7:0]);
    send(n[7:0]);
    for (int k = idx; k < idx + sent; k++) begin
      d = 8'($random(seed));
      send(d);
      if (k < 4) e[k] = d & m[k] | e[k] & ~m[k];
    end
    u_scb_host.stop;
  endtask
  task automatic rd_blk(input int idx, input int got);
    u_scb_host.start;
    send({SCB_ADDR_HI, adr_strap, 1'b0});
    send(idx[7:0]);
    u_scb_host.start;
    send({SCB_ADDR_HI, adr_strap, 1'b1});
    exp_q.push_back(8'(6 - idx));
    u_scb_host.get(1'b1);
    for (int k = idx; k < idx + got; k++) begin
      exp_q.push_back(e[k]);
      u_scb_host.get(k < idx + got - 1);
    end
    u_scb_host.stop;
  endtask
  task automatic chk_out;
    check({4'h0, out_enable}, {4'h0, e[0][6], e[0][4], e[0][3], e[0][1]});
    check({6'h0, pll_mode}, {6'h0, e[1][5] ? e[1][4:3] : bw_strap});
    check({6'h0, swing_sel}, {6'h0, e[1][1:0]});
    check({4'h0, out_edge_fast}, {4'h0, e[2][6], e[2][4], e[2][3], e[2][1]});
    check({7'h0, rate_sw_enable}, {7'h0, e[3][5]});
    check({6'h0, rate_select}, {6'h0, e[3][5] ? e[3][4:3] : 2'h0});
    check({7'h0, feedback_edge_fast}, {7'h0, e[3][0]});
  endtask
  always @(posedge clk) begin
    cycles++;
    if (rd_stb)
      check(rd_byte, exp_q.pop_front());
    if (cycles == 30000) begin
      mismatches++;
      complete_run;
    end
  end
  initial begin
    adr_strap = 3'($random(seed));
    bw_strap = 2'($random(seed));
    e = '{SCB_RST_OE, {bw_strap, SCB_RST_PLL[5:0]}, SCB_RST_SLEW, SCB_RST_FREQ,
      SCB_RST_RSVD4, {SCB_REVISION_CODE, SCB_VENDOR_CODE}};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk_out;
    rd_blk(0, 6);
    repeat (4) begin
      wr_blk(0, 6, 6);
      chk_out;
      rd_blk(0, 6);
    end
    wr_blk(1, 3, 1);
    chk_out;
    rd_blk(2, 2);
    u_scb_host.start;
    u_scb_host.xfer({SCB_ADDR_HI, ~adr_strap, 1'b0}, 1'b0, q, a);
    check({7'h0, a}, 8'h00);
    u_scb_host.stop;
    chk_out;
    repeat (4) @(posedge clk);
    complete_run;
  end
endmodule
bind scb_smbus_config scb_props u_scb_props (.clk, .rst, .scl, .sda_out, .sda_oe, .out_enable,
  .pll_mode, .swing_sel, .out_edge_fast, .rate_sw_enable, .rate_select, .feedback_edge_fast);
